/* File: pdh_pkg.sv */
// Summary of operation
// - the power-down pin acts as power-down control only while the option is set, else it is an ordinary input.
// - while power-down is high all logic state and output data are latched and held.
// - an output that was high impedance when power-down began stays high impedance throughout.
// - during power-down every input except the power-down pin is ignored.
// - during power-down the input and bidirectional hold latches keep every pin at its last level.
// - after the power-down pin falls, inputs, enables and clocks are accepted and outputs valid within 1 us.
package pdh_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAKE_TIME_NS  = 1000;
  // longest time rounds down
  localparam int unsigned WAKE_MAX_CYC  = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_SETTLE_CYC = 4;
  localparam int unsigned WAKE_CNT_W    = $clog2(WAKE_MAX_CYC + 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
    WAKE_CNT_W'(WAKE_SETTLE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = '0;

  localparam int unsigned IN_W_DEF = 4;
  localparam int unsigned IO_W_DEF = 8;

  localparam logic RST_LEVEL = 1'h0;

  typedef enum logic [1:0] {
    PDH_RUN,
    PDH_HOLD,
    PDH_WAKE
  } pdh_state_type;

endpackage : pdh_pkg

/* File: pdh_hold_if.sv */
`timescale 1ns/1ns
interface pdh_hold_if #(
  parameter int unsigned IN_W = 4,
  parameter int unsigned IO_W = 8
) (
  input wire logic clk,
  input wire logic rst_n
);
  logic            freeze;
  logic [IN_W-1:0] in_pin;
  logic [IO_W-1:0] io_pin;
  logic [IN_W-1:0] in_held;
  logic [IO_W-1:0] io_held;

  modport hold (
    input  clk,
    input  rst_n,
    input  freeze,
    input  in_pin,
    input  io_pin,
    output in_held,
    output io_held
  );

  modport ctrl (
    output freeze,
    output in_pin,
    output io_pin,
    input  in_held,
    input  io_held
  );
endinterface : pdh_hold_if

/* File: pdh_hold.sv */
`timescale 1ns/1ns
module pdh_hold #(
  parameter int unsigned IN_W = 4,
  parameter int unsigned IO_W = 8
) (
  pdh_hold_if.hold hif
);
  logic [IN_W-1:0] in_meta;
  logic [IN_W-1:0] in_sync;
  logic [IO_W-1:0] io_meta;
  logic [IO_W-1:0] io_sync;

  // pins are asynchronous to mclk
  always_ff @(posedge hif.clk or negedge hif.rst_n)
    if (!hif.rst_n)
    begin
      in_meta <= '0;
      in_sync <= '0;
      io_meta <= '0;
      io_sync <= '0;
    end
    else
    begin
      in_meta <= hif.in_pin;
      in_sync <= in_meta;
      io_meta <= hif.io_pin;
      io_sync <= io_meta;
    end

  // hold latches: frozen copy keeps the last level while blocked
  always_ff @(posedge hif.clk or negedge hif.rst_n)
    if (!hif.rst_n)
    begin
      hif.in_held <= '0;
      hif.io_held <= '0;
    end
    else if (!hif.freeze)
    begin
      hif.in_held <= in_sync;
      hif.io_held <= io_sync;
    end
endmodule : pdh_hold

/* File: pdh_top.sv */
`timescale 1ns/1ns
module pdh_top #(
  parameter int unsigned IN_W = pdh_pkg::IN_W_DEF,
  parameter int unsigned IO_W = pdh_pkg::IO_W_DEF
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // configuration and control pin
  input  wire logic            pd_option_en,
  input  wire logic            power_down_pin,
  // device pins
  input  wire logic [IN_W-1:0] in_pin,
  input  wire logic [IO_W-1:0] io_in,
  output logic      [IO_W-1:0] io_out,
  output logic      [IO_W-1:0] io_oe,
  // core logic side
  input  wire logic [IO_W-1:0] core_out,
  input  wire logic [IO_W-1:0] core_oe,
  output logic                 core_run,
  output logic      [IN_W-1:0] core_in,
  output logic      [IO_W-1:0] core_io_in,
  output logic                 pd_pin_level,
  output logic                 pd_active
);
  logic                              rst_meta;
  logic                              rst_n;
  logic                              pd_meta;
  logic                              pd_sync;
  logic                              opt_meta;
  logic                              opt_sync;
  pdh_pkg::pdh_state_type            state;
  pdh_pkg::pdh_state_type            next_state;
  logic [pdh_pkg::WAKE_CNT_W-1:0]    wake_cnt;

  // shared run decode for every register that follows the core
  function automatic logic is_run(input pdh_pkg::pdh_state_type st);
    return st == pdh_pkg::PDH_RUN;
  endfunction : is_run

  pdh_hold_if #(.IN_W(IN_W), .IO_W(IO_W)) hif (
    .clk   (mclk),
    .rst_n (rst_n)
  );

  pdh_hold #(.IN_W(IN_W), .IO_W(IO_W)) u_hold (
    .hif (hif.hold)
  );

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      rst_meta <= pdh_pkg::RST_LEVEL;
      rst_n    <= pdh_pkg::RST_LEVEL;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      pd_meta  <= 1'b0;
      pd_sync  <= 1'b0;
      opt_meta <= 1'b0;
      opt_sync <= 1'b0;
    end
    else
    begin
      pd_meta  <= power_down_pin;
      pd_sync  <= pd_meta;
      opt_meta <= pd_option_en;
      opt_sync <= opt_meta;
    end

  always_comb
  begin
    next_state = state;
    unique case (state)
      pdh_pkg::PDH_RUN:
        if (opt_sync && pd_sync)
          next_state = pdh_pkg::PDH_HOLD;
      pdh_pkg::PDH_HOLD:
        if (!pd_sync)
          next_state = pdh_pkg::PDH_WAKE;
      pdh_pkg::PDH_WAKE:
        if (pd_sync)
          next_state = pdh_pkg::PDH_HOLD;
        else if (wake_cnt == pdh_pkg::WAKE_LAST)
          next_state = pdh_pkg::PDH_RUN;
      // the unused code drops back to running instead of stalling the pins
      default:
        next_state = pdh_pkg::PDH_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      state <= pdh_pkg::PDH_RUN;
    else
      state <= next_state;

  // settle count stays well inside the wake-up limit including sync delay
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      wake_cnt <= pdh_pkg::WAKE_CNT_RST;
    else if (state == pdh_pkg::PDH_WAKE)
      wake_cnt <= wake_cnt + 1'b1;
    else
      wake_cnt <= pdh_pkg::WAKE_CNT_RST;

  assign hif.freeze = !is_run(state);
  assign hif.in_pin = in_pin;
  assign hif.io_pin = io_in;

  // core clock enable: state is frozen, never cleared, across power-down
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      core_run  <= 1'b0;
      pd_active <= 1'b0;
    end
    else
    begin
      core_run  <= is_run(next_state);
      pd_active <= !is_run(next_state);
    end

  // output data and enables only follow the core while running
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      io_out <= '0;
      io_oe  <= '0;
    end
    else if (is_run(next_state))
    begin
      io_out <= core_out;
      io_oe  <= core_oe;
    end
    else
    begin
      io_out <= io_out;
      io_oe  <= io_oe;
    end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      core_in    <= '0;
      core_io_in <= '0;
    end
    else
    begin
      core_in    <= hif.in_held;
      core_io_in <= hif.io_held;
    end

  // pin is an ordinary input only without the option
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      pd_pin_level <= 1'b0;
    else
      pd_pin_level <= opt_sync ? 1'b0 : pd_sync;
endmodule : pdh_top

/* File: pdh_checker.sv */
`timescale 1ns/1ns
module pdh_checker #(
  parameter int unsigned IN_W = 4,
  parameter int unsigned IO_W = 8
) (
  input wire logic            mclk,
  input wire logic            arst_n,
  input wire logic            pd_option_en,
  input wire logic            power_down_pin,
  input wire logic [IO_W-1:0] core_out,
  input wire logic [IO_W-1:0] io_out,
  input wire logic [IO_W-1:0] io_oe,
  input wire logic            core_run,
  input wire logic [IN_W-1:0] core_in,
  input wire logic [IO_W-1:0] core_io_in,
  input wire logic            pd_pin_level,
  input wire logic            pd_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_held;
    pd_active ##1 pd_active;
  endsequence
  property p_out; s_held |-> $stable(io_out); endproperty
  property p_oe; s_held |-> $stable(io_oe); endproperty
  property p_in; s_held |-> $stable(core_in); endproperty
  property p_keep; s_held |-> $stable(core_io_in); endproperty
  property p_opt; !pd_option_en [*4] |-> !pd_active; endproperty
  property p_stop;
    pd_option_en && $rose(power_down_pin) |-> ##3 !core_run;
  endproperty
  property p_wake; $fell(power_down_pin) |-> ##[1:25] core_run;
  endproperty
  property p_resume;
    $fell(pd_active) |-> core_run && $stable(core_in) && $stable(core_io_in);
  endproperty
  property p_follow;
    core_run && $past(core_run, 2) |-> io_out == $past(core_out);
  endproperty
  a_out: assert property (p_out) else $error("io_out moved");
  a_oe: assert property (p_oe) else $error("io_oe moved");
  a_in: assert property (p_in) else $error("core_in moved");
  a_keep: assert property (p_keep) else $error("keeper moved");
  a_opt: assert property (p_opt) else $error("hold w/o option");
  a_stop: assert property (p_stop) else $error("no hold");
  a_wake: assert property (p_wake) else $error("slow wake");
  a_resume: assert property (p_resume) else $error("no resume");
  a_follow: assert property (p_follow) else $error("stale out");
endmodule : pdh_checker
bind pdh_top pdh_checker #(.IN_W(IN_W), .IO_W(IO_W)) i_pdh_checker (
  .mclk(mclk), .arst_n(arst_n), .pd_option_en(pd_option_en),
  .power_down_pin(power_down_pin), .core_out(core_out),
  .io_out(io_out), .io_oe(io_oe), .core_run(core_run),
  .core_in(core_in), .core_io_in(core_io_in),
  .pd_pin_level(pd_pin_level), .pd_active(pd_active));

/* File: pdh_board.sv */
`timescale 1ns/1ns
module pdh_board (
  input  wire logic mclk,
  input  wire logic req,
  output logic      power_down_pin
);
  initial power_down_pin = 1'b0;
  // the pin carries only the power-down request, no logic data
  always @(negedge mclk) power_down_pin <= req;
endmodule : pdh_board

/* File: pdh_top_bench.sv */
`timescale 1ns/1ns
module pdh_top_bench;
  logic mclk = 1'b0, arst_n = 1'b0, opt = 1'b0, req = 1'b0, pd;
  logic [3:0] in_pin = 4'h3;
  logic [7:0] io_in = 8'hc3, c_out = 8'h5a, c_oe = 8'h0f;
  logic [7:0] io_out, io_oe, c_io;
  logic [3:0] c_in;
  logic run, lvl, act;
  int failures = 0, comparisons = 0;
  initial forever #20 mclk = ~mclk;
  pdh_board i_pdh_board (.mclk(mclk), .req(req), .power_down_pin(pd));
  pdh_top i_pdh_top (.mclk(mclk), .arst_n(arst_n), .pd_option_en(opt),
    .power_down_pin(pd), .in_pin(in_pin), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .core_out(c_out), .core_oe(c_oe),
    .core_run(run), .core_in(c_in), .core_io_in(c_io),
    .pd_pin_level(lvl), .pd_active(act));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task stop_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task t_hold;
    opt = 1'b1;
    repeat (8) @(negedge mclk);
    req <= 1'b1;
    repeat (6) @(negedge mclk);
    // inputs move only once the don't-care window has begun
    {in_pin, io_in, c_out, c_oe} = {4'hc, 8'h3c, 8'ha5, 8'hf0};
    repeat (10) @(negedge mclk);
    chk("run", {7'h0, run}, 8'h00);
    chk("io_out", io_out, 8'h5a);
    chk("io_oe", io_oe, 8'h0f);
    chk("core_in", {4'h0, c_in}, 8'h03);
    chk("keeper", c_io, 8'hc3);
    chk("active", {7'h0, act}, 8'h01);
    req <= 1'b0;
    repeat (26) @(negedge mclk);
    chk("woken", {7'h0, run}, 8'h01);
    chk("io_out", io_out, 8'ha5);
    chk("io_oe", io_oe, 8'hf0);
    chk("core_in", {4'h0, c_in}, 8'h0c);
    chk("keeper", c_io, 8'h3c);
    chk("active", {7'h0, act}, 8'h00);
    chk("pin lvl", {7'h0, lvl}, 8'h00);
  endtask : t_hold
  task t_off;
    opt = 1'b0;
    repeat (4) @(negedge mclk);
    req <= 1'b1;
    c_out = 8'h99;
    repeat (8) @(negedge mclk);
    chk("active", {7'h0, act}, 8'h00);
    chk("pin lvl", {7'h0, lvl}, 8'h01);
    chk("io_out", io_out, 8'h99);
    req <= 1'b0;
  endtask : t_off
  initial
  begin
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    t_hold();
    t_off();
    stop_test();
  end
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : pdh_top_bench
